//--- design/notifier_pkg.sv
// Shared constants and types for the sensor event pulse notifier
package notifier_pkg;

	// Register offsets
	localparam logic [7:0] TRIG_CFG_ADDR   = 8'h53;
	localparam logic [7:0] PCHG_CFG_ADDR   = 8'h54;
	localparam logic [7:0] EXEC_STAT_ADDR  = 8'h55;
	localparam logic [7:0] SENS_COND_ADDR  = 8'h56;
	localparam logic [7:0] COMMAND_ADDR    = 8'h57;

	// Reset values
	localparam logic [7:0] TRIG_CFG_RST    = 8'h3E;
	localparam logic [7:0] PCHG_CFG_RST    = 8'h01;
	localparam logic [7:0] EXEC_STAT_RST   = 8'h00;
	localparam logic [7:0] SENS_COND_RST   = 8'h00;

	// Trigger configuration fields
	localparam int POL_BIT         = 5;
	localparam int LEN_SEL_BIT     = 4;
	localparam int FW_TRIG_BIT     = 3;
	localparam int ST_TRIG_BIT     = 2;
	localparam int ACQ_ERR_TRIG_BIT = 1;
	localparam int RDY_TRIG_BIT    = 0;
	localparam logic [7:0] TRIG_CFG_MASK = 8'h3F;

	// Pressure change configuration fields
	localparam int SLOPE_EN_BIT    = 2;
	localparam int REL_EN_BIT      = 1;
	localparam int FIXED_EN_BIT    = 0;
	localparam logic [7:0] PCHG_CFG_MASK = 8'h07;

	// Execution status fields
	localparam int PULSE_FLAG_BIT  = 7;
	localparam int SLOPE_FLAG_BIT  = 6;
	localparam int REL_FLAG_BIT    = 5;
	localparam int FIXED_FLAG_BIT  = 4;
	localparam int FW_FLAG_BIT     = 3;
	localparam int PCELL_FLAG_BIT  = 2;
	localparam int CONV_FLAG_BIT   = 1;
	localparam int ACQ_FLAG_BIT    = 0;

	// Command register fields
	localparam int ACK_REQ_BIT     = 7;

	// Pulse timing
	localparam int CLK_HZ          = 40_000_000;
	localparam int SHORT_PULSE_MS  = 4;
	localparam int LONG_PULSE_MS   = 8;
	localparam int SHORT_PULSE_CYC = CLK_HZ / 1000 * SHORT_PULSE_MS;
	localparam int LONG_PULSE_CYC  = CLK_HZ / 1000 * LONG_PULSE_MS;
	localparam int PULSE_CNT_W     = 19;

	typedef enum logic [0:0] {
		PULSE_IDLE   = 1'b0,
		PULSE_ACTIVE = 1'b1
	} pulse_state_type;

endpackage

//--- design/pulse_timer_if.sv
// Handshake between the notifier and its pulse timer
interface pulse_timer_if;
	logic                   start;
	logic [18:0]            length;
	logic                   busy;

	modport ctrl (
		output start,
		output length,
		input  busy
	);

	modport timer (
		input  start,
		input  length,
		output busy
	);
endinterface

//--- design/pulse_timer.sv
// Timed pulse generator for the interrupt pin
module pulse_timer (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	pulse_timer_if.timer    tmr,
	input  wire logic [18:0] short_len,
	input  wire logic [18:0] long_len
);
	notifier_pkg::pulse_state_type state_ff;
	logic [18:0]                   count_ff;

	// A start while busy is ignored so a running pulse is never cut short
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= notifier_pkg::PULSE_IDLE;
			count_ff <= 19'h00000;
		end else if (clk_en) begin
			unique case (state_ff)
				notifier_pkg::PULSE_IDLE: begin
					if (tmr.start) begin
						state_ff <= notifier_pkg::PULSE_ACTIVE;
						count_ff <= tmr.length - 19'h00001;
					end
				end
				notifier_pkg::PULSE_ACTIVE: begin
					if (count_ff == 19'h00000) begin
						state_ff <= notifier_pkg::PULSE_IDLE;
					end else begin
						count_ff <= count_ff - 19'h00001;
					end
				end
			endcase
		end
	end

	assign tmr.busy = (state_ff == notifier_pkg::PULSE_ACTIVE);

	logic unused_len;
	assign unused_len = ^{short_len, long_len};
endmodule

//--- design/sensor_event_pulse_notifier.sv
// Event flags, trigger gating and interrupt pin pulse for the sensor

module sensor_event_pulse_notifier (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       transfers_done,
	input  wire logic       fw_check_done,
	input  wire logic       fw_check_err,
	input  wire logic       pcell_test_done,
	input  wire logic       pcell_test_err,
	input  wire logic       conv_test_done,
	input  wire logic       conv_test_err,
	input  wire logic       acq_done,
	input  wire logic [7:0] acq_condition,
	input  wire logic       slope_exceeded,
	input  wire logic       relative_exceeded,
	input  wire logic       fixed_exceeded,
	output logic [7:0]      reg_rdata,
	output logic            irq_pin,
	output logic            slope_monitor_en,
	output logic            relative_monitor_en,
	output logic            fixed_monitor_en
);
	// Pulse lengths in ref_clk cycles; the timer loads one at each start
	localparam logic [18:0] SHORT_LEN =
		19'(notifier_pkg::SHORT_PULSE_CYC);
	localparam logic [18:0] LONG_LEN =
		19'(notifier_pkg::LONG_PULSE_CYC);

	logic [7:0] trig_cfg_ff;
	logic [7:0] pchg_cfg_ff;
	logic [7:0] exec_stat_ff;
	logic [7:0] sens_cond_ff;
	logic       ack_req_ff;
	logic       irq_pin_ff;
	logic [7:0] rdata_ff;
	logic       slope_en_ff;
	logic       rel_en_ff;
	logic       fixed_en_ff;

	logic       irq_pulse_polarity;
	logic       irq_pulse_length_sel;
	logic       firmware_check_trigger_en;
	logic       selftest_trigger_en;
	logic       acquisition_error_trigger_en;
	logic       data_ready_trigger_en;

	logic       acq_has_err;
	logic       slope_hit;
	logic       rel_hit;
	logic       fixed_hit;
	logic       pulse_req;
	logic       ack_now;
	logic [7:0] nxt_exec_stat;
	logic [7:0] nxt_sens_cond;

	// Per-source pulse requests
	logic       thr_req;
	logic       fw_req;
	logic       st_err;
	logic       st_req;
	logic       acq_err_req;
	logic       rdy_req;

	pulse_timer_if tmr ();

	assign irq_pulse_polarity = trig_cfg_ff[notifier_pkg::POL_BIT];
	assign irq_pulse_length_sel = trig_cfg_ff[notifier_pkg::LEN_SEL_BIT];
	assign firmware_check_trigger_en =
		trig_cfg_ff[notifier_pkg::FW_TRIG_BIT];
	assign selftest_trigger_en = trig_cfg_ff[notifier_pkg::ST_TRIG_BIT];
	assign acquisition_error_trigger_en =
		trig_cfg_ff[notifier_pkg::ACQ_ERR_TRIG_BIT];
	assign data_ready_trigger_en = trig_cfg_ff[notifier_pkg::RDY_TRIG_BIT];

	// Any condition bit marks the acquisition as errored
	assign acq_has_err = |acq_condition;
	// Threshold results only count while their monitor is enabled
	assign slope_hit = slope_exceeded &
		pchg_cfg_ff[notifier_pkg::SLOPE_EN_BIT];
	assign rel_hit = relative_exceeded &
		pchg_cfg_ff[notifier_pkg::REL_EN_BIT];
	assign fixed_hit = fixed_exceeded &
		pchg_cfg_ff[notifier_pkg::FIXED_EN_BIT];

	// One gated request per trigger source
	assign thr_req = slope_hit | rel_hit | fixed_hit;
	assign fw_req = fw_check_done & fw_check_err &
		firmware_check_trigger_en;
	// Both self-tests share one trigger enable
	assign st_err = (pcell_test_done & pcell_test_err) |
		(conv_test_done & conv_test_err);
	assign st_req = st_err & selftest_trigger_en;
	// An errored acquisition may raise both the error and the ready term
	assign acq_err_req = acq_done & acq_has_err &
		acquisition_error_trigger_en;
	// Data ready fires on every completion, errored or not
	assign rdy_req = acq_done & data_ready_trigger_en;

	// Any enabled event asks for a pulse
	always_comb begin
		pulse_req = 1'b0;
		if (thr_req) begin
			pulse_req = 1'b1;
		end
		if (fw_req) begin
			pulse_req = 1'b1;
		end
		if (st_req) begin
			pulse_req = 1'b1;
		end
		if (acq_err_req) begin
			pulse_req = 1'b1;
		end
		if (rdy_req) begin
			pulse_req = 1'b1;
		end
	end

	// Clearing waits for the host to finish its transfers, so a read in
	// flight still sees the flags that caused the pulse
	assign ack_now = ack_req_ff && transfers_done;

	// Status update: acknowledge clears first, same-cycle events then win
	always_comb begin
		nxt_exec_stat = ack_now ? 8'h00 : exec_stat_ff;
		// Threshold flags only set; result flags track the latest run
		if (slope_hit) begin
			nxt_exec_stat[notifier_pkg::SLOPE_FLAG_BIT] = 1'b1;
		end
		if (rel_hit) begin
			nxt_exec_stat[notifier_pkg::REL_FLAG_BIT] = 1'b1;
		end
		if (fixed_hit) begin
			nxt_exec_stat[notifier_pkg::FIXED_FLAG_BIT] = 1'b1;
		end
		if (fw_check_done) begin
			nxt_exec_stat[notifier_pkg::FW_FLAG_BIT] = fw_check_err;
		end
		if (pcell_test_done) begin
			nxt_exec_stat[notifier_pkg::PCELL_FLAG_BIT] =
				pcell_test_err;
		end
		if (conv_test_done) begin
			nxt_exec_stat[notifier_pkg::CONV_FLAG_BIT] =
				conv_test_err;
		end
		if (acq_done) begin
			nxt_exec_stat[notifier_pkg::ACQ_FLAG_BIT] =
				acq_has_err;
		end
		if (pulse_req) begin
			nxt_exec_stat[notifier_pkg::PULSE_FLAG_BIT] = 1'b1;
		end
	end

	// Condition register follows the latest acquisition
	always_comb begin
		nxt_sens_cond = ack_now ? 8'h00 : sens_cond_ff;
		if (acq_done) begin
			nxt_sens_cond = acq_condition;
		end
	end

	// Status flags: acknowledge and events meet in nxt_exec_stat
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			exec_stat_ff <= notifier_pkg::EXEC_STAT_RST;
		end else if (clk_en) begin
			exec_stat_ff <= nxt_exec_stat;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sens_cond_ff <= notifier_pkg::SENS_COND_RST;
		end else if (clk_en) begin
			sens_cond_ff <= nxt_sens_cond;
		end
	end

	// Configuration registers; reserved bits stay zero
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			trig_cfg_ff <= notifier_pkg::TRIG_CFG_RST;
		end else if (clk_en && reg_wr &&
			reg_addr == notifier_pkg::TRIG_CFG_ADDR) begin
			trig_cfg_ff <= reg_wdata & notifier_pkg::TRIG_CFG_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pchg_cfg_ff <= notifier_pkg::PCHG_CFG_RST;
		end else if (clk_en && reg_wr &&
			reg_addr == notifier_pkg::PCHG_CFG_ADDR) begin
			pchg_cfg_ff <= reg_wdata & notifier_pkg::PCHG_CFG_MASK;
		end
	end

	// Acknowledge request holds until transfers end, then self-clears
	// A request written in the clearing cycle stands for the next round
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_req_ff <= 1'b0;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == notifier_pkg::COMMAND_ADDR &&
				reg_wdata[notifier_pkg::ACK_REQ_BIT]) begin
				ack_req_ff <= 1'b1;
			end else if (ack_now) begin
				ack_req_ff <= 1'b0;
			end
		end
	end

	// Registered read data, one cycle after the address
	// Status registers have no write path; only events and acknowledge move
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= 8'h00;
		end else if (clk_en) begin
			unique case (reg_addr)
				notifier_pkg::TRIG_CFG_ADDR:  rdata_ff <= trig_cfg_ff;
				notifier_pkg::PCHG_CFG_ADDR:  rdata_ff <= pchg_cfg_ff;
				notifier_pkg::EXEC_STAT_ADDR: rdata_ff <= exec_stat_ff;
				notifier_pkg::SENS_COND_ADDR: rdata_ff <= sens_cond_ff;
				notifier_pkg::COMMAND_ADDR: begin
					rdata_ff <= {ack_req_ff, 7'h00};
				end
				default:                      rdata_ff <= 8'h00;
			endcase
		end
	end

	// Starts while busy are dropped in the timer, so no pulse is stretched
	assign tmr.start = pulse_req;
	assign tmr.length = irq_pulse_length_sel ? LONG_LEN : SHORT_LEN;

	pulse_timer u_pulse_timer (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.clk_en    (clk_en),
		.tmr       (tmr.timer),
		.short_len (SHORT_LEN),
		.long_len  (LONG_LEN)
	);

	// Pin level is registered; polarity changes apply to idle level too
	// The register also keeps decode hazards off the host's input
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_pin_ff <= 1'b0;
		end else if (clk_en) begin
			irq_pin_ff <= tmr.busy ~^ irq_pulse_polarity;
		end
	end

	// Monitor enables go out registered, one cycle behind the config write
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			slope_en_ff <= 1'b0;
			rel_en_ff   <= 1'b0;
			fixed_en_ff <= 1'b0;
		end else if (clk_en) begin
			slope_en_ff <= pchg_cfg_ff[notifier_pkg::SLOPE_EN_BIT];
			rel_en_ff   <= pchg_cfg_ff[notifier_pkg::REL_EN_BIT];
			fixed_en_ff <= pchg_cfg_ff[notifier_pkg::FIXED_EN_BIT];
		end
	end

	assign reg_rdata           = rdata_ff;
	assign irq_pin             = irq_pin_ff;
	assign slope_monitor_en    = slope_en_ff;
	assign relative_monitor_en = rel_en_ff;
	assign fixed_monitor_en    = fixed_en_ff;
endmodule

//--- verif/notifier_checker_assertions.sv
// Concurrent checks on the notifier top module ports
module notifier_checker (
	input wire logic       ref_clk,
	input wire logic       reset_n,
	input wire logic       clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic       fw_check_done,
	input wire logic       fw_check_err,
	input wire logic       pcell_test_done,
	input wire logic       pcell_test_err,
	input wire logic       conv_test_done,
	input wire logic       conv_test_err,
	input wire logic       acq_done,
	input wire logic [7:0] acq_condition,
	input wire logic       slope_exceeded,
	input wire logic       relative_exceeded,
	input wire logic       fixed_exceeded,
	input wire logic       irq_pin,
	input wire logic       slope_monitor_en,
	input wire logic       relative_monitor_en,
	input wire logic       fixed_monitor_en
);
	logic [7:0]  trig_ff;
	logic [18:0] act_cnt_ff;
	wire         pol = trig_ff[notifier_pkg::POL_BIT];
	wire         fw_hit = fw_check_done & fw_check_err & trig_ff[3];
	wire         st_err = pcell_test_done & pcell_test_err
		| conv_test_done & conv_test_err;
	wire         acq_bad = acq_done & (acq_condition != 8'h00);
	wire         thr_hit = slope_exceeded & slope_monitor_en
		| relative_exceeded & relative_monitor_en
		| fixed_exceeded & fixed_monitor_en;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// Shadow of the trigger register, so the idle level is known
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			trig_ff <= notifier_pkg::TRIG_CFG_RST;
		else if (clk_en && reg_wr &&
			reg_addr == notifier_pkg::TRIG_CFG_ADDR)
			trig_ff <= reg_wdata & notifier_pkg::TRIG_CFG_MASK;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			act_cnt_ff <= 19'h00000;
		else if (clk_en)
			act_cnt_ff <= (irq_pin == pol) ?
				act_cnt_ff + 19'h00001 : 19'h00000;
	end

	// Pin must go active two edges after an enabled event seen while idle
	property p_start(logic hit);
		clk_en && hit && irq_pin != pol && !reg_wr |=> ##1 irq_pin == pol;
	endproperty

	a_fw_pulse: assert property (p_start(fw_hit))
		else $error("no pulse after firmware check error");
	a_test_pulse: assert property (p_start(st_err & trig_ff[2]))
		else $error("no pulse after self-test error");
	a_acq_err_pulse: assert property (p_start(acq_bad & trig_ff[1]))
		else $error("no pulse after acquisition error");
	a_ready_pulse: assert property (p_start(acq_done & trig_ff[0]))
		else $error("no pulse after data ready");
	a_thresh_pulse: assert property (p_start(thr_hit))
		else $error("no pulse after threshold exceeded");
	a_mon_copy: assert property (clk_en && reg_wr &&
		reg_addr == notifier_pkg::PCHG_CFG_ADDR |-> ##2
		{slope_monitor_en, relative_monitor_en, fixed_monitor_en}
		== $past(reg_wdata[2:0], 2))
		else $error("monitor enables differ from written config");
	a_pulse_max: assert property (act_cnt_ff <=
		notifier_pkg::LONG_PULSE_CYC)
		else $error("pulse longer than the long length");
	a_pulse_whole: assert property (irq_pin != pol &&
		act_cnt_ff != 19'h00000 && pol == $past(pol, 2) |->
		act_cnt_ff == notifier_pkg::SHORT_PULSE_CYC ||
		act_cnt_ff == notifier_pkg::LONG_PULSE_CYC)
		else $error("pulse ended at a wrong length");

	c_fw: cover property (fw_hit && irq_pin != pol);
	c_thr: cover property (thr_hit && irq_pin == pol);
	c_end: cover property (irq_pin != pol && act_cnt_ff != 19'h00000);
endmodule

bind sensor_event_pulse_notifier notifier_checker chk (.*);

//--- verif/irq_host_model.sv
// Host side model that watches the interrupt pin and times each pulse
module irq_host_model (
	input  wire logic        ref_clk,
	input  wire logic        irq_pin,
	input  wire logic        active_level,
	output logic [7:0]       pulse_count,
	output logic [18:0]      last_width
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [18:0] width_ff = 19'h00000;

	initial begin
		pulse_count = 8'h00;
		last_width = 19'h00000;
	end

	// A pulse cut short by a device reset is counted too
	always @(posedge ref_clk) begin
		if (irq_pin === active_level) begin
			width_ff <= width_ff + 19'h00001;
		end else if (width_ff != 19'h00000) begin
			last_width <= width_ff;
			pulse_count <= pulse_count + 8'h01;
			width_ff <= 19'h00000;
		end
	end
endmodule

//--- verif/test_sensor_event_pulse_notifier.sv
// Register and event tests for the sensor event pulse notifier
module test_sensor_event_pulse_notifier;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk, reset_n, clk_en, reg_wr, transfers_done;
	logic        fw_check_done, fw_check_err, pcell_test_done;
	logic        pcell_test_err, conv_test_done, conv_test_err, acq_done;
	logic        slope_exceeded, relative_exceeded, fixed_exceeded;
	logic [7:0]  reg_addr, reg_wdata, acq_condition, reg_rdata, n0, exp_v;
	logic        irq_pin, slope_monitor_en, relative_monitor_en;
	logic        fixed_monitor_en;
	logic [7:0]  pulse_count;
	logic [18:0] last_width;
	int          n_errors = 0;
	int          check_count = 0;
	localparam logic [7:0] TRIG_OF [8] = '{8'h08, 8'h04, 8'h04, 8'h02,
		8'h01, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] FLAG_OF [8] = '{8'h08, 8'h04, 8'h02, 8'h01,
		8'h00, 8'h40, 8'h20, 8'h10};

	sensor_event_pulse_notifier DUT (.*);
	irq_host_model host (.ref_clk(ref_clk), .irq_pin(irq_pin),
		.active_level(1'b1), .pulse_count(pulse_count),
		.last_width(last_width));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [18:0] exp,
		input logic [18:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		repeat (2) @(posedge ref_clk);
		#1 check("reg_rdata", exp, reg_rdata);
	endtask

	task automatic do_reset();
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
	endtask

	// One cycle event strobe; the error levels ride with their done strobe
	task automatic fire(input int e);
		@(posedge ref_clk);
		case (e)
			0: {fw_check_done, fw_check_err} <= 2'b11;
			1: {pcell_test_done, pcell_test_err} <= 2'b11;
			2: {conv_test_done, conv_test_err} <= 2'b11;
			3: {acq_done, acq_condition} <= {1'b1, 8'h01};
			4: acq_done <= 1'b1;
			5: slope_exceeded <= 1'b1;
			6: relative_exceeded <= 1'b1;
			default: fixed_exceeded <= 1'b1;
		endcase
		@(posedge ref_clk);
		{fw_check_done, fw_check_err, pcell_test_done, pcell_test_err,
			conv_test_done, conv_test_err, acq_done, acq_condition,
			slope_exceeded, relative_exceeded, fixed_exceeded} <= '0;
	endtask

	task automatic give_verdict();
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		{fw_check_done, fw_check_err, pcell_test_done, pcell_test_err,
			conv_test_done, conv_test_err, acq_done, acq_condition,
			slope_exceeded, relative_exceeded, fixed_exceeded, reg_wr,
			transfers_done, reg_addr, reg_wdata, reset_n} = '0;
		clk_en = 1'b1;
		do_reset();
		rd(notifier_pkg::TRIG_CFG_ADDR, 8'h3E);
		rd(notifier_pkg::PCHG_CFG_ADDR, 8'h01);
		rd(notifier_pkg::EXEC_STAT_ADDR, 8'h00);
		rd(8'h60, 8'h00);
		check("fixed_monitor_en", 1'b1, fixed_monitor_en);
		check("irq_pin", 1'b0, irq_pin);
		wr(notifier_pkg::TRIG_CFG_ADDR, 8'hFF);
		rd(notifier_pkg::TRIG_CFG_ADDR, 8'h3F);
		wr(notifier_pkg::EXEC_STAT_ADDR, 8'hFF);
		rd(notifier_pkg::EXEC_STAT_ADDR, 8'h00);
		wr(notifier_pkg::PCHG_CFG_ADDR, 8'h06);
		rd(notifier_pkg::PCHG_CFG_ADDR, 8'h06);
		check("monitor_en", 3'b110, {slope_monitor_en,
			relative_monitor_en, fixed_monitor_en});
		// A write while the clock enable is low must be lost
		@(posedge ref_clk);
		clk_en <= 1'b0;
		wr(notifier_pkg::PCHG_CFG_ADDR, 8'h00);
		clk_en <= 1'b1;
		rd(notifier_pkg::PCHG_CFG_ADDR, 8'h06);
		wr(notifier_pkg::TRIG_CFG_ADDR, 8'h1F);
		repeat (3) @(posedge ref_clk);
		check("irq_pin", 1'b1, irq_pin);
		for (int e = 0; e < 8; e++) begin
			for (int en = 0; en < 2; en++) begin
				do_reset();
				// Odd events run with an active-low pin
				wr(notifier_pkg::TRIG_CFG_ADDR,
					(e % 2 ? 8'h00 : 8'h20) | (en ? TRIG_OF[e] : 8'h00));
				wr(notifier_pkg::PCHG_CFG_ADDR,
					(en == 1 && e > 4) ? 8'h07 : 8'h00);
				fire(e);
				exp_v = ((en == 1 || e < 5) ? FLAG_OF[e] : 8'h00)
					| (en ? 8'h80 : 8'h00);
				rd(notifier_pkg::EXEC_STAT_ADDR,
					exp_v);
				rd(notifier_pkg::SENS_COND_ADDR,
					(e == 3) ? 8'h01 : 8'h00);
				check("irq_pin", (en == 1) == (e % 2 == 0),
					irq_pin);
			end
		end
		// Late event, then acknowledge held off until transfers end
		do_reset();
		wr(notifier_pkg::TRIG_CFG_ADDR, 8'h28);
		n0 = pulse_count;
		fire(0);
		repeat (5) @(posedge ref_clk);
		fire(7);
		rd(notifier_pkg::EXEC_STAT_ADDR, 8'h98);
		wr(notifier_pkg::COMMAND_ADDR, 8'h80);
		rd(notifier_pkg::EXEC_STAT_ADDR, 8'h98);
		rd(notifier_pkg::COMMAND_ADDR, 8'h80);
		@(posedge ref_clk);
		transfers_done <= 1'b1;
		@(posedge ref_clk);
		transfers_done <= 1'b0;
		rd(notifier_pkg::EXEC_STAT_ADDR, 8'h00);
		rd(notifier_pkg::COMMAND_ADDR, 8'h00);
		for (int i = 0; i < 170000 && pulse_count == n0; i++)
			@(posedge ref_clk);
		check("pulse_count", n0 + 8'h01, pulse_count);
		check("pulse_width", 19'(notifier_pkg::SHORT_PULSE_CYC),
			last_width);
		give_verdict();
	end

	initial begin
		#5_000_000;
		n_errors++;
		give_verdict();
	end
endmodule
